// >>> inc/twsf_map.vh
// register map, codes and timing constants for the two-wire slave front end
`ifndef TWSF_MAP_VH
`define TWSF_MAP_VH
`define TWSF_CTRL_OFS 8'h77
`define TWSF_CTRL_RST 8'h60
`define TWSF_BIT_MODE 0
`define TWSF_BIT_ENA 1
`define TWSF_BIT_ADR 2
`define TWSF_BIT_LCK 4
`define TWSF_BIT_SDAO 5
`define TWSF_BIT_SCLO 6
`define TWSF_ADDR_BASE 7'h50
`define TWSF_LEAD_OK 8'h0e
`define TWSF_LEAD_ERR 8'h0f
`define TWSF_ANS_ACK 8'h06
`define TWSF_ANS_BEL 8'h07
`define TWSF_ANS_NAK 8'h15
`define TWSF_CMD_CONF 8'h84
`define TWSF_CMD_DIAG 8'h8c
`define TWSF_PAR1 8'he5
`define TWSF_PAR2 8'h5e
`define TWSF_WINDOW_US 32'h64
`define TWSF_CLK_MHZ 32'h32
`define TWSF_WINDOW_CYC (`TWSF_WINDOW_US * `TWSF_CLK_MHZ)
`define TWSF_PORDLY_CYC 32'h10
`define TWSF_PROC_CYC 8'h40
`define TWSF_MODE_WIN 2'h0
`define TWSF_MODE_OPER 2'h1
`define TWSF_MODE_CONF 2'h2
`define TWSF_MODE_DIAG 2'h3
`endif

// >>> design/twsf_front_end.v
// two-wire slave front end with shared command engine framing and startup window
//
// Function
// - interface-enable 0 ignores two-wire traffic; pins become general purpose
// - device never stretches the clock line
// - device is target only, never starts a transfer
// - address 0x50..0x53 chosen by two-bit select field
// - write frame: acknowledge address and every following byte
// - while answer pending, not-acknowledge read frames including address
// - commandless read returns fast-channel words, upper four bits zero
// - word-count bit: 0 one word, 1 two words
// - commandless lead byte 0x0E when no enabled error
// - commandless lead byte 0x0F when enabled error present
// - command-lock bit 1 blocks command interpretation on both links
// - one shared engine decodes commands from either link identically
// - startup window opens once after power-on delay
// - single-wire driver high impedance during startup window
// - window closes without entry command: operational, driver on, link off
// - valid entry command in window enters configuration or diagnosis
// - configuration or diagnosis held until reset
// - command is two to five bytes, code first, checksum last
// - checksum equals sum of preceding bytes plus one modulo 256
// - single-wire answer sent unprompted; two-wire answer held until read
// - answer status 0x06 ack, 0x07 ack with error, 0x15 nack
// - entry commands 0x84 / 0x8C with parameters 0xE5 0x5E and checksum
`timescale 1ns/1ps
`include "twsf_map.vh"
module twsf_front_end #(
    parameter WINDOW_CYC = `TWSF_WINDOW_CYC
) (
    input wire clk,
    input wire srst,
    input wire sclIn,
    input wire sdaIn,
    output reg sclOut_ff,
    output reg sclOe_ff,
    output reg sdaOut_ff,
    output reg sdaOe_ff,
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData_ff,
    input wire [11:0] fastWord1Value,
    input wire [11:0] fastWord2Value,
    input wire errPresent,
    input wire sioRxValid,
    input wire [7:0] sioRxByte,
    input wire sioRxEnd,
    output reg sioTxValid_ff,
    output reg [7:0] sioTxByte_ff,
    output reg sentDrvEn_ff,
    output reg sioLinkEn_ff,
    output reg [1:0] opMode_ff
);
    // control register and pin synchronisers
    reg [7:0] ctrl_ff;
    reg [1:0] sclSync_ff, sdaSync_ff;
    reg sclD_ff, sdaD_ff;
    always @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= `TWSF_CTRL_RST;
            regRdData_ff <= 8'h00;
            sclSync_ff <= 2'h3;
            sdaSync_ff <= 2'h3;
            sclD_ff <= 1'b1;
            sdaD_ff <= 1'b1;
        end else begin
            if (regWrEn && regAddr == `TWSF_CTRL_OFS)
                ctrl_ff <= regWrData & 8'h7f;
            if (regRdEn)
                regRdData_ff <= (regAddr == `TWSF_CTRL_OFS) ? ctrl_ff : 8'h00;
            sclSync_ff <= {sclSync_ff[0], sclIn};
            sdaSync_ff <= {sdaSync_ff[0], sdaIn};
            sclD_ff <= sclSync_ff[1];
            sdaD_ff <= sdaSync_ff[1];
        end
    end
    wire ifEn = ctrl_ff[`TWSF_BIT_ENA];
    wire scl = sclSync_ff[1];
    wire sda = sdaSync_ff[1];
    wire sclRise = scl && !sclD_ff;
    wire sclFall = !scl && sclD_ff;
    wire startCond = scl && sclD_ff && sdaD_ff && !sda;
    wire stopCond = scl && sclD_ff && !sdaD_ff && sda;
    wire [6:0] myAddr = `TWSF_ADDR_BASE + {5'h00, ctrl_ff[`TWSF_BIT_ADR+1:`TWSF_BIT_ADR]};

    // startup window and mode
    reg [31:0] winCnt_ff;
    reg inWin_ff;
    reg [1:0] engEnter;
    reg answerTaken;
    always @(posedge clk) begin
        if (srst) begin
            winCnt_ff <= 32'h0;
            inWin_ff <= 1'b0;
            opMode_ff <= `TWSF_MODE_WIN;
            sentDrvEn_ff <= 1'b0;
            sioLinkEn_ff <= 1'b1;
        end else begin
            if (opMode_ff == `TWSF_MODE_WIN) begin
                winCnt_ff <= winCnt_ff + 32'h1;
                inWin_ff <= (winCnt_ff >= `TWSF_PORDLY_CYC);
                if (engEnter == 2'h1)
                    opMode_ff <= `TWSF_MODE_CONF;
                else if (engEnter == 2'h2)
                    opMode_ff <= `TWSF_MODE_DIAG;
                else if (winCnt_ff == WINDOW_CYC + `TWSF_PORDLY_CYC) begin
                    opMode_ff <= `TWSF_MODE_OPER;
                    sentDrvEn_ff <= 1'b1;
                    sioLinkEn_ff <= 1'b0;
                end
            end else begin
                inWin_ff <= 1'b0;
            end
        end
    end

    // shared command engine: frames bytes, checks sum, builds answer
    reg [2:0] cmdLen_ff;
    reg [7:0] cmdB0_ff, cmdB1_ff, cmdB2_ff, sum_ff, lastByte_ff;
    reg pending_ff, ansReady_ff, ansFromSio_ff;
    reg [7:0] ansByte_ff;
    reg [7:0] procCnt_ff;
    wire i2cByteIn, sioOk;
    wire [7:0] i2cByte;
    wire frameEndI2c;
    assign sioOk = sioLinkEn_ff && sioRxValid && !ctrl_ff[`TWSF_BIT_LCK];
    wire byteIn = (i2cByteIn && !ctrl_ff[`TWSF_BIT_LCK]) || sioOk;
    wire [7:0] inByte = sioOk ? sioRxByte : i2cByte;
    wire frameEnd = frameEndI2c || (sioLinkEn_ff && sioRxEnd);
    wire sumOk = (lastByte_ff == sum_ff);
    wire isEntry = cmdLen_ff == 3'h4 && (cmdB0_ff == `TWSF_CMD_CONF || cmdB0_ff == `TWSF_CMD_DIAG)
        && cmdB1_ff == `TWSF_PAR1 && cmdB2_ff == `TWSF_PAR2;
    always @* begin
        engEnter = 2'h0;
        if (procCnt_ff == 8'h01 && isEntry && sumOk && inWin_ff)
            engEnter = (cmdB0_ff == `TWSF_CMD_CONF) ? 2'h1 : 2'h2;
    end
    always @(posedge clk) begin
        if (srst) begin
            cmdLen_ff <= 3'h0;
            cmdB0_ff <= 8'h00;
            cmdB1_ff <= 8'h00;
            cmdB2_ff <= 8'h00;
            sum_ff <= 8'h01;
            lastByte_ff <= 8'h00;
            pending_ff <= 1'b0;
            ansReady_ff <= 1'b0;
            ansFromSio_ff <= 1'b0;
            ansByte_ff <= 8'h00;
            procCnt_ff <= 8'h00;
            sioTxValid_ff <= 1'b0;
            sioTxByte_ff <= 8'h00;
        end else begin
            sioTxValid_ff <= 1'b0;
            if (byteIn && !pending_ff) begin
                if (cmdLen_ff != 3'h0)
                    sum_ff <= sum_ff + lastByte_ff;
                lastByte_ff <= inByte;
                if (cmdLen_ff == 3'h0)
                    cmdB0_ff <= inByte;
                if (cmdLen_ff == 3'h1)
                    cmdB1_ff <= inByte;
                if (cmdLen_ff == 3'h2)
                    cmdB2_ff <= inByte;
                if (cmdLen_ff != 3'h7)
                    cmdLen_ff <= cmdLen_ff + 3'h1;
                ansFromSio_ff <= sioOk;
                ansReady_ff <= 1'b0;
            end else if (frameEnd && cmdLen_ff != 3'h0 && !pending_ff) begin
                pending_ff <= 1'b1;
                procCnt_ff <= `TWSF_PROC_CYC;
            end
            if (pending_ff) begin
                procCnt_ff <= procCnt_ff - 8'h01;
                if (procCnt_ff == 8'h01) begin
                    pending_ff <= 1'b0;
                    cmdLen_ff <= 3'h0;
                    sum_ff <= 8'h01;
                    if (cmdLen_ff >= 3'h2 && cmdLen_ff <= 3'h5 && sumOk && isEntry && inWin_ff)
                        ansByte_ff <= errPresent ? `TWSF_ANS_BEL : `TWSF_ANS_ACK;
                    else
                        ansByte_ff <= `TWSF_ANS_NAK;
                    if (ansFromSio_ff) begin
                        sioTxValid_ff <= 1'b1;
                        sioTxByte_ff <= (cmdLen_ff >= 3'h2 && sumOk && isEntry && inWin_ff) ?
                            (errPresent ? `TWSF_ANS_BEL : `TWSF_ANS_ACK) : `TWSF_ANS_NAK;
                    end else
                        ansReady_ff <= 1'b1;
                end
            end else if (answerTaken)
                ansReady_ff <= 1'b0;
        end
    end

    // two-wire target state machine
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WR = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RD = 3'h5;
    localparam ST_RACK = 3'h6;
    reg [2:0] st_ff;
    reg [7:0] sh_ff;
    reg [3:0] bitCnt_ff;
    reg [2:0] rdIdx_ff;
    reg isRead_ff, cla_ff, hold_ff;
    assign i2cByteIn = (st_ff == ST_WR) && sclRise && bitCnt_ff == 4'h7;
    assign i2cByte = {sh_ff[6:0], sda};
    assign frameEndI2c = ifEn && stopCond && !isRead_ff;
    wire [15:0] w1 = {4'h0, fastWord1Value};
    wire [15:0] w2 = {4'h0, fastWord2Value};
    reg [7:0] rdByte;
    always @* begin
        answerTaken = ifEn && (st_ff == ST_RD) && !cla_ff && sclRise && bitCnt_ff == 4'h7;
        case (rdIdx_ff)
            3'h0: rdByte = errPresent ? `TWSF_LEAD_ERR : `TWSF_LEAD_OK;
            3'h1: rdByte = w1[15:8];
            3'h2: rdByte = w1[7:0];
            3'h3: rdByte = w2[15:8];
            3'h4: rdByte = w2[7:0];
            default: rdByte = 8'hff;
        endcase
        if (!cla_ff)
            rdByte = (rdIdx_ff == 3'h0) ? ansByte_ff : 8'hff;
    end
    wire [2:0] lastIdx = ctrl_ff[`TWSF_BIT_MODE] ? 3'h4 : 3'h2;
    always @(posedge clk) begin
        if (srst || !ifEn) begin
            st_ff <= ST_IDLE;
            sh_ff <= 8'h00;
            bitCnt_ff <= 4'h0;
            rdIdx_ff <= 3'h0;
            isRead_ff <= 1'b0;
            cla_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else if (startCond) begin
            st_ff <= ST_ADDR;
            bitCnt_ff <= 4'h0;
            hold_ff <= 1'b0;
        end else if (stopCond) begin
            st_ff <= ST_IDLE;
            hold_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_ADDR: begin
                    if (sclRise) begin
                        sh_ff <= {sh_ff[6:0], sda};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    if (sclFall && bitCnt_ff == 4'h8) begin
                        isRead_ff <= sh_ff[0];
                        cla_ff <= !ansReady_ff;
                        rdIdx_ff <= 3'h0;
                        if (sh_ff[7:1] == myAddr && !(sh_ff[0] && pending_ff)) begin
                            st_ff <= ST_AACK;
                            hold_ff <= 1'b1;
                        end else
                            st_ff <= ST_IDLE;
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (sclFall) begin
                        bitCnt_ff <= 4'h0;
                        hold_ff <= isRead_ff;
                        st_ff <= isRead_ff ? ST_RD : ST_WR;
                        if (isRead_ff)
                            sh_ff <= rdByte;
                    end
                end
                ST_WR: begin
                    if (sclRise) begin
                        sh_ff <= {sh_ff[6:0], sda};
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                    if (sclFall && bitCnt_ff == 4'h8) begin
                        st_ff <= ST_WACK;
                        hold_ff <= 1'b1;
                    end
                end
                ST_RD: begin
                    if (sclFall) begin
                        if (bitCnt_ff == 4'h8) begin
                            st_ff <= ST_RACK;
                            hold_ff <= 1'b0;
                        end else begin
                            sh_ff <= {sh_ff[6:0], 1'b1};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                    end
                    if (sclRise && bitCnt_ff == 4'h7)
                        bitCnt_ff <= 4'h8;
                end
                ST_RACK: begin
                    if (sclRise) begin
                        if (sda || (cla_ff ? rdIdx_ff == lastIdx : 1'b1))
                            st_ff <= ST_IDLE;
                        else
                            rdIdx_ff <= rdIdx_ff + 3'h1;
                    end
                    if (sclFall && st_ff == ST_RACK) begin
                        st_ff <= ST_RD;
                        sh_ff <= rdByte;
                        bitCnt_ff <= 4'h0;
                        hold_ff <= 1'b1;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // pin drivers; clock pin only driven as general purpose output
    always @(posedge clk) begin
        if (srst) begin
            sclOut_ff <= 1'b1;
            sclOe_ff <= 1'b0;
            sdaOut_ff <= 1'b1;
            sdaOe_ff <= 1'b0;
        end else if (!ifEn) begin
            sclOut_ff <= ctrl_ff[`TWSF_BIT_SCLO];
            sclOe_ff <= 1'b1;
            sdaOut_ff <= ctrl_ff[`TWSF_BIT_SDAO];
            sdaOe_ff <= 1'b1;
        end else begin
            sclOut_ff <= 1'b1;
            sclOe_ff <= 1'b0;
            sdaOut_ff <= 1'b0;
            sdaOe_ff <= hold_ff && (st_ff == ST_RD ? !sh_ff[7] : 1'b1);
        end
    end
endmodule

// >>> tb/twsf_bus_master.sv
// two-wire bus master model driving the front end pins
`timescale 1ns/1ps
module twsf_bus_master (
    input wire clk,
    input wire sdaLine,
    output reg sclDrv,
    output reg sdaDrv
);
    // released lines float to the pull-up level
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // data set mid low phase, sampled at the end of the high phase
    task bitx(input b, output r);
        begin
            tick(2);
            sdaDrv <= b;
            tick(2);
            sclDrv <= 1'b1;
            tick(4);
            r = sdaLine;
            sclDrv <= 1'b0;
        end
    endtask
    // only this bus is used, the single-wire link stays idle meanwhile
    task start;
        begin
            tick(4);
            sdaDrv <= 1'b0;
            tick(4);
            sclDrv <= 1'b0;
        end
    endtask
    task stop;
        begin
            tick(2);
            sdaDrv <= 1'b0;
            tick(2);
            sclDrv <= 1'b1;
            tick(4);
            sdaDrv <= 1'b1;
            tick(4);
        end
    endtask
    task sendByte(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(d[i], r);
            bitx(1'b1, ack);
        end
    endtask
    task recvByte(input last, output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(1'b1, d[i]);
            bitx(last, r);
        end
    endtask
endmodule

// >>> tb/twsf_fe_monitor.sv
// assertion checker on the front end ports
`timescale 1ns/1ps
module twsf_fe_monitor (
    input wire clk,
    input wire srst,
    input wire sclIn,
    input wire sclOe_ff,
    input wire sdaOut_ff,
    input wire sdaOe_ff,
    input wire regWrEn,
    input wire regRdEn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData_ff,
    input wire sioTxValid_ff,
    input wire sentDrvEn_ff,
    input wire sioLinkEn_ff,
    input wire [1:0] opMode_ff
);
    reg [7:0] ctrlSh_ff;
    reg [3:0] hiCnt_ff;
    wire busOn = ctrlSh_ff[1];
    wire pull = sdaOe_ff & ~sdaOut_ff;
    always @(posedge clk) begin
        if (srst) begin
            ctrlSh_ff <= 8'h60;
            hiCnt_ff <= 4'h0;
        end else begin
            if (regWrEn && regAddr == 8'h77) begin
                ctrlSh_ff <= {1'b0, regWrData[6:0]};
            end
            hiCnt_ff <= sclIn ? hiCnt_ff + {3'h0, hiCnt_ff != 4'hf} : 4'h0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    no_clock_stretch_a: assert property (busOn && $past(busOn, 3) |-> !sclOe_ff)
        else $error("clock pin driven in bus mode");
    no_start_drive_a: assert property (busOn && $past(busOn, 3) && $rose(pull) |-> hiCnt_ff < 4'h6)
        else $error("data pulled low while clock idle high");
    no_stop_release_a: assert property (busOn && $past(busOn, 3) && $fell(pull) |-> hiCnt_ff < 4'h6)
        else $error("data released while clock idle high");
    sio_tx_link_a: assert property (sioTxValid_ff |-> sioLinkEn_ff)
        else $error("answer sent with link disabled");
    window_hiz_a: assert property (opMode_ff == 2'h0 |-> !sentDrvEn_ff)
        else $error("output driver on in window");
    oper_driver_a: assert property (opMode_ff == 2'h1 && $past(opMode_ff) == 2'h1
        |-> sentDrvEn_ff && !sioLinkEn_ff)
        else $error("operational outputs wrong");
    mode_held_a: assert property (opMode_ff[1] |=> $stable(opMode_ff))
        else $error("mode left without reset");
    window_once_a: assert property (opMode_ff != 2'h0 |=> opMode_ff != 2'h0)
        else $error("window reopened");
    entry_source_a: assert property ($rose(opMode_ff[1]) |-> $past(opMode_ff) == 2'h0)
        else $error("entry outside window");
    ctrl_read_a: assert property ($past(regRdEn && regAddr == 8'h77) |-> regRdData_ff == ctrlSh_ff)
        else $error("control read mismatch");
endmodule
bind twsf_front_end twsf_fe_monitor u_mon (.clk, .srst, .sclIn, .sclOe_ff, .sdaOut_ff, .sdaOe_ff,
    .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_ff, .sioTxValid_ff, .sentDrvEn_ff,
    .sioLinkEn_ff, .opMode_ff);

// >>> tb/testbench.sv
// register and bus tests for the two-wire front end
`timescale 1ns/1ps
module testbench;
    reg clk, srst, regWrEn, regRdEn, errPresent, sioRxValid, sioRxEnd;
    reg [7:0] regAddr, regWrData, sioRxByte, sioGot, d;
    reg [11:0] fastWord1Value, fastWord2Value;
    wire sclOut_ff, sclOe_ff, sdaOut_ff, sdaOe_ff, sioTxValid_ff, sentDrvEn_ff, sioLinkEn_ff, mScl, mSda;
    wire [7:0] regRdData_ff, sioTxByte_ff;
    wire [1:0] opMode_ff;
    wire sclW = sclOe_ff ? sclOut_ff : mScl;
    wire sdaW = mSda & ~(sdaOe_ff & ~sdaOut_ff);
    integer errTotal = 0, checksDone = 0, k;
    twsf_front_end #(.WINDOW_CYC(3000)) DUT (.clk, .srst, .sclIn(sclW), .sdaIn(sdaW), .sclOut_ff,
        .sclOe_ff, .sdaOut_ff, .sdaOe_ff, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_ff,
        .fastWord1Value, .fastWord2Value, .errPresent, .sioRxValid, .sioRxByte, .sioRxEnd,
        .sioTxValid_ff, .sioTxByte_ff, .sentDrvEn_ff, .sioLinkEn_ff, .opMode_ff);
    twsf_bus_master mst (.clk(clk), .sdaLine(sdaW), .sclDrv(mScl), .sdaDrv(mSda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (sioTxValid_ff) sioGot <= sioTxByte_ff;
    task chk(input [7:0] g, input [7:0] e);
        begin
            checksDone = checksDone + 1;
            if (g !== e) begin
                errTotal = errTotal + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", checksDone, errTotal);
            if (errTotal == 0 && checksDone > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task doReset;
        begin
            srst <= 1'b1;
            repeat (4) @(posedge clk);
            srst <= 1'b0;
        end
    endtask
    task regWr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk);
            regWrEn <= 1'b1;
            regAddr <= a;
            regWrData <= v;
            @(posedge clk);
            regWrEn <= 1'b0;
        end
    endtask
    task regRd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk);
            regRdEn <= 1'b1;
            regAddr <= a;
            @(posedge clk);
            regRdEn <= 1'b0;
            @(posedge clk);
            chk(regRdData_ff, e);
        end
    endtask
    task nakFrame(input [7:0] a);
        reg r;
        begin
            mst.start;
            mst.sendByte(a, r);
            chk({7'h0, r}, 8'h01);
            mst.stop;
        end
    endtask
    task rdFrame(input [7:0] a, input integer n, input [7:0] lead);
        reg [7:0] e [0:4];
        reg r;
        integer i;
        begin
            e[0] = lead;
            e[1] = {4'h0, fastWord1Value[11:8]};
            e[2] = fastWord1Value[7:0];
            e[3] = {4'h0, fastWord2Value[11:8]};
            e[4] = fastWord2Value[7:0];
            mst.start;
            mst.sendByte(a, r);
            chk({7'h0, r}, 8'h00);
            for (i = 0; i < n; i = i + 1) begin
                mst.recvByte(i == n - 1, d);
                chk(d, e[i]);
            end
            mst.stop;
        end
    endtask
    task cmd(input sio, input [7:0] c, input [7:0] s, input ca);
        reg [7:0] b [0:4];
        reg r;
        integer i;
        begin
            b[0] = 8'ha0;
            b[1] = c;
            b[2] = 8'he5;
            b[3] = 8'h5e;
            b[4] = c + 8'he5 + 8'h5e + 8'h01 + s;
            if (!sio) mst.start;
            for (i = sio; i < 5; i = i + 1) begin
                if (sio) begin
                    @(posedge clk);
                    sioRxValid <= 1'b1;
                    sioRxByte <= b[i];
                    @(posedge clk);
                    sioRxValid <= 1'b0;
                    sioRxEnd <= (i == 4);
                end else begin
                    mst.sendByte(b[i], r);
                    if (ca) chk({7'h0, r}, 8'h00);
                end
            end
            if (!sio) mst.stop;
            @(posedge clk);
            sioRxEnd <= 1'b0;
        end
    endtask
    initial begin
        srst = 1'b1;
        {regWrEn, regRdEn, errPresent, sioRxValid, sioRxEnd} = 5'h00;
        {regAddr, regWrData, sioRxByte, sioGot} = 32'h0;
        fastWord1Value = 12'ha5c;
        fastWord2Value = 12'h3b7;
        doReset;
        regRd(8'h77, 8'h60);
        regRd(8'h30, 8'h00);
        nakFrame(8'ha0);
        regWr(8'h77, 8'h40);
        mst.tick(3);
        chk({4'h0, sclOe_ff, sclOut_ff, sdaOe_ff, sdaOut_ff}, 8'h0e);
        regWr(8'h77, 8'h62);
        cmd(0, 8'h84, 8'h00, 1);
        mst.tick(80);
        rdFrame(8'ha1, 1, 8'h06);
        chk({6'h0, opMode_ff}, 8'h02);
        for (k = 0; k < 4; k = k + 1) begin
            regWr(8'h77, 8'h62 | {k[1:0], 2'b00});
            rdFrame(8'ha1 + {k[1:0], 1'b0}, 1, 8'h0e);
            nakFrame(8'ha1 + {k[1:0] + 2'h1, 1'b0});
        end
        for (k = 0; k < 4; k = k + 1) begin
            errPresent <= k[1];
            fastWord1Value <= fastWord1Value + 12'h111;
            fastWord2Value <= fastWord2Value - 12'h101;
            regWr(8'h77, 8'h62 | {7'h0, k[0]});
            rdFrame(8'ha1, k[0] ? 5 : 3, k[1] ? 8'h0f : 8'h0e);
        end
        mst.tick(3100);
        chk({6'h0, opMode_ff}, 8'h02);
        $display("test 1 done");
        doReset;
        cmd(1, 8'h8c, 8'h01, 0);
        mst.tick(150);
        chk(sioGot, 8'h15);
        cmd(1, 8'h8c, 8'h00, 0);
        mst.tick(150);
        chk(sioGot, 8'h07);
        chk({6'h0, opMode_ff}, 8'h03);
        $display("test 2 done");
        doReset;
        regWr(8'h77, 8'h72);
        cmd(0, 8'h84, 8'h00, 0);
        mst.tick(3100);
        chk({6'h0, opMode_ff}, 8'h01);
        chk({6'h0, sentDrvEn_ff, sioLinkEn_ff}, 8'h02);
        $display("test 3 done");
        finish_test;
    end
    initial begin
        #800000;
        errTotal = errTotal + 1;
        finish_test;
    end
endmodule
